// ===== verilog/apr2_pkg.sv
// Constants, register map and field layout of the second alert pin router
//
// Contract
// - A writable routing register at offset 0x28 assigns each alert condition with a set bit to the second alert pin.
// - The routing bits steer the pin only while the pin function is set to alert mode.
// - A condition reaches the pin only when it is also enabled in the global alert enable register.
// - Bits 23 to 20 route the overcurrent alerts of channels 1 to 4.
// - Bits 19 to 16 route the undercurrent alerts of channels 1 to 4.
// - Bits 15 to 12 route the overvoltage alerts of channels 1 to 4.
// - Bits 11 to 8 route the undervoltage alerts of channels 1 to 4.
// - Bits 7 to 4 route the overpower alerts of channels 1 to 4.
// - All routing bits clear at power-on and bit 0 ignores writes and reads as zero.
// - Bit 3 routes the alert raised when any channel accumulator passes its fullness limit.
// - Bit 2 routes the alert raised when the sample count passes its fullness limit.
// - With bit 1 set in alert mode the pin is asserted for 5 us after every conversion cycle.
package apr2_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int ROUTE_W = 24;
   localparam int STAT_W = 3;
   localparam int CNT_W = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_ROUTE = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h2a;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h2b;
   localparam logic [ADDR_W-1:0] OFS_ACTIVE = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h2d;

   // Reset values and write masks
   localparam logic [ROUTE_W-1:0] ROUTE_RESET = 24'h000000;
   localparam logic [ROUTE_W-1:0] ROUTE_WMASK = 24'hfffffe;
   localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
   localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

   // Field layout of the routing word, channel 1 at the top bit of each group
   localparam int CHANNELS = 4;
   localparam int OC_MSB = 23;
   localparam int UC_MSB = 19;
   localparam int OV_MSB = 15;
   localparam int UV_MSB = 11;
   localparam int OP_MSB = 7;
   localparam int ACC_FULL_BIT = 3;
   localparam int COUNT_FULL_BIT = 2;
   localparam int CONV_PULSE_BIT = 1;
   localparam int UNIMP_BIT = 0;

   // Interrupt status bits
   localparam int STAT_PIN_RISE = 0;
   localparam int STAT_CONV_PULSE = 1;
   localparam int STAT_BLOCKED = 2;

   // Conversion-done pulse length
   localparam int CLK_MHZ = 125;
   localparam int PULSE_NS = 5000;
   localparam int PULSE_CYCLES = (PULSE_NS * CLK_MHZ + 999) / 1000;

   // Pulse timer states
   typedef enum logic [0:0] {
      PT_IDLE,
      PT_HIGH
   } apr2_pulse_state_t;

endpackage

// ===== verilog/apr2_pulse_timer.sv
// Retriggerable fixed-length pulse timer for the conversion-done alert
`timescale 1ns/10ps
module apr2_pulse_timer #(
   parameter int CYCLES = apr2_pkg::PULSE_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic trigger,
   output logic      pulseOut
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
   localparam logic [CW-1:0] ZERO = '0;

   apr2_pkg::apr2_pulse_state_t state_r;
   apr2_pkg::apr2_pulse_state_t state_nxt;
   logic [CW-1:0]               count_r;
   logic [CW-1:0]               count_nxt;

   // A new trigger restarts the full length, so back-to-back conversions merge
   always_comb
   begin
      state_nxt = state_r;
      count_nxt = count_r;
      case (state_r)
         apr2_pkg::PT_IDLE:
         begin
            if (trigger)
            begin
               state_nxt = apr2_pkg::PT_HIGH;
               count_nxt = LOAD;
            end
         end
         apr2_pkg::PT_HIGH:
         begin
            if (trigger)
               count_nxt = LOAD;
            else if (count_r == ZERO)
               state_nxt = apr2_pkg::PT_IDLE;
            else
               count_nxt = count_r - CW'(1);
         end
         default:
         begin
            state_nxt = apr2_pkg::PT_IDLE;
            count_nxt = ZERO;
         end
      endcase
   end

   // State and counter
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= apr2_pkg::PT_IDLE;
         count_r <= ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         count_r <= count_nxt;
      end
   end

   // High for exactly CYCLES clocks after a lone trigger
   assign pulseOut = (state_r == apr2_pkg::PT_HIGH);

endmodule // apr2_pulse_timer

// ===== verilog/apr2_router.sv
// Second alert pin source router with routing register and interrupt status
`timescale 1ns/10ps
module apr2_router #(
   parameter int PULSE_CYCLES = apr2_pkg::PULSE_CYCLES
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   input  wire logic [apr2_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [apr2_pkg::DATA_W-1:0] regWrData,
   input  wire logic                        regWrStb,
   input  wire logic                        regRdStb,
   output logic      [apr2_pkg::DATA_W-1:0] regRdData,
   input  wire logic                        pinAlertMode,
   input  wire logic [apr2_pkg::ROUTE_W-1:0] alertEnable,
   input  wire logic [apr2_pkg::CHANNELS-1:0] overCurrent,
   input  wire logic [apr2_pkg::CHANNELS-1:0] underCurrent,
   input  wire logic [apr2_pkg::CHANNELS-1:0] overVoltage,
   input  wire logic [apr2_pkg::CHANNELS-1:0] underVoltage,
   input  wire logic [apr2_pkg::CHANNELS-1:0] overPower,
   input  wire logic                        accumulatorFull,
   input  wire logic                        sampleCountFull,
   input  wire logic                        conversionDone,
   output logic                             secondAlertPin,
   output logic                             irq
);

   // Local widths
   localparam int RW = apr2_pkg::ROUTE_W;
   localparam int SW = apr2_pkg::STAT_W;
   localparam int CW = apr2_pkg::CNT_W;
   localparam int DW = apr2_pkg::DATA_W;

   // Register state
   logic [RW-1:0] alertPin2Routing_r;
   logic [RW-1:0] alertPin2Routing_nxt;
   logic [SW-1:0] status_r;
   logic [SW-1:0] status_nxt;
   logic [SW-1:0] mask_r;
   logic [SW-1:0] mask_nxt;
   logic [CW-1:0] riseCount_r;
   logic [CW-1:0] riseCount_nxt;
   logic [DW-1:0] rdData_r;
   logic [DW-1:0] rdData_nxt;
   logic          pin_r;
   logic          pin_nxt;
   logic          irq_r;
   logic          irq_nxt;

   // Source assembly and gating
   logic [RW-1:0] sourceVec;
   logic [RW-1:0] enabledVec;
   logic [RW-1:0] routedVec;
   logic          anyRouted;
   logic          pulseArm;
   logic          pulseTrig;
   logic          pulseHigh;
   logic          pinRise;
   logic          blockedEvent;
   logic [SW-1:0] statusSet;
   logic [SW-1:0] statusClr;

   // Bus decode
   logic          hitRoute;
   logic          hitStatus;
   logic          hitMask;
   logic          hitActive;
   logic          hitCount;
   logic          wrRoute;
   logic          wrStatus;
   logic          wrMask;
   logic [DW-1:0] rdMux;

   // Address decode against the fixed map
   assign hitRoute  = (regAddr == apr2_pkg::OFS_ROUTE);
   assign hitStatus = (regAddr == apr2_pkg::OFS_STATUS);
   assign hitMask   = (regAddr == apr2_pkg::OFS_MASK);
   assign hitActive = (regAddr == apr2_pkg::OFS_ACTIVE);
   assign hitCount  = (regAddr == apr2_pkg::OFS_COUNT);

   // Write qualifiers
   assign wrRoute  = regWrStb & hitRoute;
   assign wrStatus = regWrStb & hitStatus;
   assign wrMask   = regWrStb & hitMask;

   // Per-channel placement of the comparator outputs, channel 1 highest
   genvar ch;
   generate
      for (ch = 0; ch < apr2_pkg::CHANNELS; ch++)
      begin : g_chan
         assign sourceVec[apr2_pkg::OC_MSB - ch] = overCurrent[ch];
         assign sourceVec[apr2_pkg::UC_MSB - ch] = underCurrent[ch];
         assign sourceVec[apr2_pkg::OV_MSB - ch] = overVoltage[ch];
         assign sourceVec[apr2_pkg::UV_MSB - ch] = underVoltage[ch];
         assign sourceVec[apr2_pkg::OP_MSB - ch] = overPower[ch];
      end
   endgenerate

   // Shared conditions, the stretched conversion pulse and the dead bit
   assign sourceVec[apr2_pkg::ACC_FULL_BIT]   = accumulatorFull;
   assign sourceVec[apr2_pkg::COUNT_FULL_BIT] = sampleCountFull;
   assign sourceVec[apr2_pkg::CONV_PULSE_BIT] = pulseHigh;
   assign sourceVec[apr2_pkg::UNIMP_BIT]      = 1'b0;

   // Conversion pulse is only started when it can actually reach the pin
   assign pulseArm = pinAlertMode
                   & alertEnable[apr2_pkg::CONV_PULSE_BIT]
                   & alertPin2Routing_r[apr2_pkg::CONV_PULSE_BIT];
   assign pulseTrig = conversionDone & pulseArm;

   // Fixed 5 us high time per completed conversion
   apr2_pulse_timer #(
      .CYCLES   (PULSE_CYCLES)
   ) u_pulse (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .trigger  (pulseTrig),
      .pulseOut (pulseHigh)
   );

   // Global enable first, then this pin's routing
   assign enabledVec = sourceVec & alertEnable;
   assign routedVec  = enabledVec & alertPin2Routing_r;
   assign anyRouted  = |routedVec;

   // Routing has no effect on the pin while the pin serves another function
   assign pin_nxt = pinAlertMode & anyRouted;

   // Pin events for the interrupt status
   assign pinRise      = pin_nxt & ~pin_r;
   assign blockedEvent = anyRouted & ~pinAlertMode;

   // Sticky status sources
   always_comb
   begin
      statusSet = '0;
      statusSet[apr2_pkg::STAT_PIN_RISE]   = pinRise;
      statusSet[apr2_pkg::STAT_CONV_PULSE] = pulseTrig;
      statusSet[apr2_pkg::STAT_BLOCKED]    = blockedEvent;
   end

   // Write one to clear; a set in the same cycle wins so no event is lost
   assign statusClr  = wrStatus ? regWrData[SW-1:0] : '0;
   assign status_nxt = (status_r & ~statusClr) | statusSet;

   // Mask register, same layout as status
   assign mask_nxt = wrMask ? regWrData[SW-1:0] : mask_r;

   // Interrupt level, registered so the output comes straight off a flop
   assign irq_nxt = |(status_nxt & mask_nxt);

   // Unimplemented bit kept at zero regardless of write data
   assign alertPin2Routing_nxt = wrRoute
                               ? (regWrData[RW-1:0] & apr2_pkg::ROUTE_WMASK)
                               : alertPin2Routing_r;

   // Pin assertion counter, saturating so a stuck alert cannot wrap to zero
   assign riseCount_nxt = (pinRise && (riseCount_r != '1))
                        ? riseCount_r + CW'(1)
                        : riseCount_r;

   // Read selection; unmapped addresses read as zero
   always_comb
   begin
      rdMux = '0;
      if (hitRoute)
         rdMux[RW-1:0] = alertPin2Routing_r;
      else if (hitStatus)
         rdMux[SW-1:0] = status_r;
      else if (hitMask)
         rdMux[SW-1:0] = mask_r;
      else if (hitActive)
         rdMux[RW-1:0] = routedVec;
      else if (hitCount)
         rdMux[CW-1:0] = riseCount_r;
   end

   // Read data valid only in the cycle after the strobe
   assign rdData_nxt = regRdStb ? rdMux : '0;

   // Routing register, clears at power-on
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         alertPin2Routing_r <= apr2_pkg::ROUTE_RESET;
      else
         alertPin2Routing_r <= alertPin2Routing_nxt;
   end

   // Interrupt status and mask
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_r <= apr2_pkg::STAT_RESET;
         mask_r   <= apr2_pkg::MASK_RESET;
         irq_r    <= 1'b0;
      end
      else
      begin
         status_r <= status_nxt;
         mask_r   <= mask_nxt;
         irq_r    <= irq_nxt;
      end
   end

   // Pin drive and assertion count
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_r       <= 1'b0;
         riseCount_r <= apr2_pkg::CNT_RESET;
      end
      else
      begin
         pin_r       <= pin_nxt;
         riseCount_r <= riseCount_nxt;
      end
   end

   // Read data register
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdData_r <= '0;
      else
         rdData_r <= rdData_nxt;
   end

   // Outputs straight from flops; one cycle behind the sources
   assign secondAlertPin = pin_r;
   assign irq            = irq_r;
   assign regRdData      = rdData_r;

endmodule // apr2_router

// ===== test/apr2_router_assertions.sv
// Concurrent checks on the ports of the second alert pin router
`timescale 1ns/10ps
module apr2_router_checker #(
   parameter int PULSE_CYCLES = apr2_pkg::PULSE_CYCLES
) (
   input wire logic                          sys_clk,
   input wire logic                          rst_n,
   input wire logic [apr2_pkg::ADDR_W-1:0]   regAddr,
   input wire logic [apr2_pkg::DATA_W-1:0]   regWrData,
   input wire logic                          regWrStb,
   input wire logic                          regRdStb,
   input wire logic [apr2_pkg::DATA_W-1:0]   regRdData,
   input wire logic                          pinAlertMode,
   input wire logic [apr2_pkg::ROUTE_W-1:0]  alertEnable,
   input wire logic [apr2_pkg::CHANNELS-1:0] overCurrent,
   input wire logic [apr2_pkg::CHANNELS-1:0] underCurrent,
   input wire logic [apr2_pkg::CHANNELS-1:0] overVoltage,
   input wire logic [apr2_pkg::CHANNELS-1:0] underVoltage,
   input wire logic [apr2_pkg::CHANNELS-1:0] overPower,
   input wire logic                          accumulatorFull,
   input wire logic                          sampleCountFull,
   input wire logic                          conversionDone,
   input wire logic                          secondAlertPin,
   input wire logic                          irq
);
   logic [15:0]                  sinceConv_r;
   logic [apr2_pkg::ROUTE_W-1:0] srcVec;
   logic                         srcEn;

   // Level sources in routing-word order, channel 1 on the top bit of each group
   always_comb
   begin
      srcVec = '0;
      for (int c = 0; c < apr2_pkg::CHANNELS; c++)
      begin
         srcVec[apr2_pkg::OC_MSB - c] = overCurrent[c];
         srcVec[apr2_pkg::UC_MSB - c] = underCurrent[c];
         srcVec[apr2_pkg::OV_MSB - c] = overVoltage[c];
         srcVec[apr2_pkg::UV_MSB - c] = underVoltage[c];
         srcVec[apr2_pkg::OP_MSB - c] = overPower[c];
      end
      srcVec[apr2_pkg::ACC_FULL_BIT]   = accumulatorFull;
      srcVec[apr2_pkg::COUNT_FULL_BIT] = sampleCountFull;
   end

   // Enabled level sources; routing itself is not visible here
   assign srcEn = |(srcVec & alertEnable);

   // Cycles since the last conversion, saturating so it never wraps into a pulse
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         sinceConv_r <= 16'h0000;
      else if (conversionDone)
         sinceConv_r <= 16'h0001;
      else if (sinceConv_r != 16'hffff)
         sinceConv_r <= sinceConv_r + 16'h0001;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_pin_needs_mode: assert property (secondAlertPin |-> $past(pinAlertMode))
      else $error("alert pin high outside alert mode");
   a_pin_needs_enable: assert property (secondAlertPin |-> $past(|alertEnable))
      else $error("alert pin high with every alert disabled");
   a_rise_has_cause: assert property ($rose(secondAlertPin) |->
      $past(srcEn) || $past(conversionDone, 2))
      else $error("alert pin rose without an enabled source");
   a_pulse_ends: assert property (sinceConv_r > PULSE_CYCLES + 1 && !$past(srcEn)
      |-> !secondAlertPin)
      else $error("conversion pulse outlived its length");
   a_read_one_cycle: assert property (!$past(regRdStb) |-> regRdData == '0)
      else $error("read data outside the answer cycle");
   a_route_bit0: assert property ($past(regRdStb && regAddr == apr2_pkg::OFS_ROUTE)
      |-> regRdData[0] == 1'b0 && regRdData[31:24] == 8'h00)
      else $error("routing word reads unimplemented bits");
   a_unmapped_zero: assert property ($past(regRdStb && regAddr == 8'h29) |->
      regRdData == '0)
      else $error("unmapped read not zero");
   a_irq_rise_cause: assert property ($rose(irq) |-> $rose(secondAlertPin) ||
      $past(regWrStb) || $past(conversionDone) || $past(conversionDone, 2) ||
      $past(!pinAlertMode && srcEn))
      else $error("interrupt rose without an event");
endmodule // apr2_router_checker

bind apr2_router apr2_router_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_apr2_router_checker (
   .sys_clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
   .pinAlertMode, .alertEnable, .overCurrent, .underCurrent, .overVoltage,
   .underVoltage, .overPower, .accumulatorFull, .sampleCountFull, .conversionDone,
   .secondAlertPin, .irq
);

// ===== test/apr2_pin_monitor.sv
// Host-side watcher of the second alert pin: rises and last high length
`timescale 1ns/10ps
module apr2_pin_monitor (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        secondAlertPin,
   output logic      [15:0] riseCount,
   output logic      [15:0] lastHigh
);
   logic [15:0] run_r;
   logic        pin_r;

   // Length is latched on the fall, so a retriggered pulse shows as one long run
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run_r     <= 16'h0000;
         pin_r     <= 1'b0;
         riseCount <= 16'h0000;
         lastHigh  <= 16'h0000;
      end
      else
      begin
         pin_r <= secondAlertPin;
         run_r <= secondAlertPin ? run_r + 16'h0001 : 16'h0000;
         if (secondAlertPin && !pin_r)
            riseCount <= riseCount + 16'h0001;
         if (!secondAlertPin && pin_r)
            lastHigh <= run_r;
      end
   end
endmodule // apr2_pin_monitor

// ===== test/tb_top.sv
// Self-checking bench of the second alert pin router
`timescale 1ns/10ps
module tb_top;
   localparam int          PULSE = 5000 / 8; // 5 us at the 8 ns bench clock
   localparam logic [23:0] ALL   = 24'hffffff;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic        regWrStb = 1'b0;
   logic        regRdStb = 1'b0;
   logic [31:0] regRdData;
   logic        pinAlertMode = 1'b0;
   logic [23:0] alertEnable = 24'h0;
   logic [3:0]  overCurrent = 4'h0, underCurrent = 4'h0, overVoltage = 4'h0;
   logic [3:0]  underVoltage = 4'h0, overPower = 4'h0;
   logic        accumulatorFull = 1'b0, sampleCountFull = 1'b0, conversionDone = 1'b0;
   logic        secondAlertPin, irq;
   logic [15:0] riseCount, lastHigh;
   int          fails = 0;
   int          compares = 0;

   always #4 sys_clk = ~sys_clk;

   apr2_router #(.PULSE_CYCLES(PULSE)) i_apr2_router (
      .sys_clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
      .pinAlertMode, .alertEnable, .overCurrent, .underCurrent, .overVoltage,
      .underVoltage, .overPower, .accumulatorFull, .sampleCountFull, .conversionDone,
      .secondAlertPin, .irq
   );
   apr2_pin_monitor i_apr2_pin_monitor (.sys_clk, .rst_n, .secondAlertPin, .riseCount, .lastHigh);

   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   // Bus cycles: one strobe cycle each, read data checked in the answer cycle
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 chk(name, exp, regRdData);
   endtask

   // Apply mode, enables and sources in routing-word order, then look at the pin
   task automatic step(logic m, logic [23:0] en, logic [23:0] v, logic exp, string name);
      @(posedge sys_clk);
      pinAlertMode <= m;
      alertEnable <= en;
      overCurrent <= {<<{v[23:20]}};
      underCurrent <= {<<{v[19:16]}};
      overVoltage <= {<<{v[15:12]}};
      underVoltage <= {<<{v[11:8]}};
      overPower <= {<<{v[7:4]}};
      accumulatorFull <= v[3];
      sampleCountFull <= v[2];
      repeat (2) @(posedge sys_clk);
      #1 chk(name, exp, secondAlertPin);
   endtask

   task automatic pulse();
      @(posedge sys_clk);
      conversionDone <= 1'b1;
      @(posedge sys_clk);
      conversionDone <= 1'b0;
   endtask

   // Bounded wait for the pin to drop; the extra edge lets the monitor latch
   task automatic waitLow();
      int n;
      n = 0;
      repeat (2) @(negedge sys_clk);
      while (secondAlertPin !== 1'b0 && n < 1000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 1000)
      begin
         fails++;
         conclude();
      end
      @(negedge sys_clk);
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(8'h28, 32'h0, "route reset");
      rd(8'h2d, 32'h0, "count reset");
      wr(8'h28, 32'hffffffff);
      rd(8'h28, 32'h00fffffe, "route readback");
      wr(8'h2c, 32'hffffffff);
      rd(8'h2c, 32'h0, "active read-only");
      wr(8'h29, 32'hffffffff);
      rd(8'h29, 32'h0, "unmapped");
      // Every level source bit, 2 to 23, against its own routing bit, its enable and the mode
      for (int i = 2; i < 24; i++)
      begin
         wr(8'h28, 32'h1 << i);
         step(1'b1, ALL, ALL ^ (24'h1 << i), 1'b0, "foreign sources");
         step(1'b1, ALL, 24'h1 << i, 1'b1, "own source");
         step(1'b1, ALL ^ (24'h1 << i), 24'h1 << i, 1'b0, "enable off");
         step(1'b0, ALL, 24'h1 << i, 1'b0, "mode off");
         step(1'b1, 24'h0, 24'h0, 1'b0, "quiet");
      end
      rd(8'h2d, 32'h16, "rise count");
      // Conversion pulse, retriggered pulse, and unrouted pulse
      wr(8'h28, 32'h2);
      step(1'b1, ALL, 24'h0, 1'b0, "armed idle");
      pulse();
      waitLow();
      chk("pulse length", PULSE, lastHigh);
      pulse();
      repeat (2) @(posedge sys_clk);
      pulse();
      waitLow();
      chk("retrigger length", PULSE + 4, lastHigh);
      wr(8'h28, 32'h0);
      pulse();
      repeat (4) @(posedge sys_clk);
      #1 chk("unrouted pulse", 32'h18, riseCount);
      // Sticky status, mask and write-one-to-clear; all three events have fired by now
      rd(8'h2a, 32'h7, "status all events");
      wr(8'h2a, 32'h7);
      rd(8'h2a, 32'h0, "status cleared");
      wr(8'h2b, 32'h1);
      wr(8'h28, 32'h800000);
      step(1'b1, ALL, 24'h800000, 1'b1, "ch1 overcurrent");
      chk("irq set", 1'b1, irq);
      rd(8'h2c, 32'h800000, "active sources");
      wr(8'h2b, 32'h0);
      #1 chk("irq masked", 1'b0, irq);
      rd(8'h2a, 32'h1, "status sticky");
      wr(8'h2b, 32'h1);
      step(1'b1, 24'h0, 24'h0, 1'b0, "source gone");
      chk("irq held", 1'b1, irq);
      wr(8'h2a, 32'h1);
      #1 chk("irq cleared", 1'b0, irq);
      rd(8'h2b, 32'h1, "mask readback");
      conclude();
   end
endmodule // tb_top
